// *** design/mic_irq_ctrl.sv ***
/*
 * Interrupt controller of a small microcontroller: seven request flags with
 * enables, a global enable, vectoring with program counter push, return
 * handling and wake-up from low-power modes, with two control registers on APB.
 * Assumes event inputs are synchronous single-cycle pulses (levels for the
 * comparator and debounce outputs) and that the cpu holds cpu_irq_window high
 * only at an instruction boundary where it can accept a vector.
 */
// Added by the designer: the register offsets and register access over APB.
`include "mic_params.svh"

// Notes on behaviour
// - A source event always sets its flag, whatever the enables say.
// - A source vectors only when both its flag and enable are high.
// - No vector is taken while the global enable is low.
// - Taking an interrupt pushes the next pc and loads the source vector.
// - Return from interrupt pops the saved pc from the stack.
// - Taking any interrupt clears the global enable.
// - Requests during service still set and hold their flags.
// - No interrupt is acknowledged while the stack is full.
// - Simultaneous enabled requests are served in a fixed priority order.
// - Some sources own a vector, others share a multi-function vector.
// - Any flag becoming set wakes the device from sleep or idle.
// - Comparator output change sets its flag; service clears it.
// - Debounce output change sets its flag; service clears it.
// - First register: global, three enables, three flags, bit 7 zero, reset zero.
// - Second register: four enables then four flags, all read/write, reset zero.
// - Flag 1 means pending; enable 1 means enabled.
// - Return from interrupt sets the global enable; plain return does not.
// - A flag holds until serviced or cleared by software.
// - Wake-up follows a flag rising, regardless of any enable.
module mic_irq_ctrl #(
    parameter logic [`MIC_NSRC*`MIC_PC_W-1:0] VECTORS = `MIC_VECTORS_DEF,
    parameter logic [`MIC_NSRC*`MIC_IDX_W-1:0] PRIO = `MIC_PRIO_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire mic_pkg::mic_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire mic_pkg::mic_data_t pwdata,
    output mic_pkg::mic_data_t prdata,
    output logic pready,
    output logic pslverr,
    // event sources
    input wire logic cmp_out,
    input wire logic debounce_out,
    input wire logic timebase_a_tick,
    input wire logic timebase_b_tick,
    input wire logic eeprom_write_done,
    input wire logic timer_match_p,
    input wire logic timer_match_a,
    // cpu core and stack
    input wire logic cpu_irq_window,
    input wire mic_pkg::mic_pc_t cpu_next_pc,
    input wire logic stack_full,
    input wire logic return_from_irq_instr_exec,
    input wire logic low_power_mode,
    output logic irq_take,
    output mic_pkg::mic_pc_t irq_vector,
    output mic_pkg::mic_pc_t stack_push_pc,
    output logic stack_pop,
    output logic wake_req
);
    import mic_pkg::*;

    mic_state_s st_reg;
    mic_state_s st_next;
    mic_src_t ev;
    mic_src_t pending;
    logic pick_hit;
    mic_idx_t pick_idx;
    logic do_take;
    logic bus_done;
    logic wr_a;
    logic wr_b;
    mic_sel_e sel;

    function automatic mic_sel_e decode(input mic_addr_t a);
        if (a == `MIC_ADDR_CTRL_A) begin
            return MIC_SEL_A;
        end else if (a == `MIC_ADDR_CTRL_B) begin
            return MIC_SEL_B;
        end else begin
            return MIC_SEL_NONE;
        end
    endfunction

    function automatic logic [7:0] pack_a(input mic_state_s s);
        return {1'b0, s.flag[`MIC_A_NSRC-1:0], s.en[`MIC_A_NSRC-1:0], s.gie};
    endfunction

    function automatic logic [7:0] pack_b(input mic_state_s s);
        return {s.flag[`MIC_NSRC-1:`MIC_A_NSRC], s.en[`MIC_NSRC-1:`MIC_A_NSRC]};
    endfunction

    mic_prio_pick #(
        .ORDER(PRIO)
    ) u_pick (
        .pending(pending),
        .hit(pick_hit),
        .idx(pick_idx)
    );

    always_comb begin
        ev = '0;
        // the first cycle after reset only learns the levels, so no false edge
        ev[`MIC_SRC_CMP] = st_reg.prev_valid && (cmp_out != st_reg.cmp_prev);
        ev[`MIC_SRC_DEB] = st_reg.prev_valid && (debounce_out != st_reg.deb_prev);
        ev[`MIC_SRC_TBA] = timebase_a_tick;
        ev[`MIC_SRC_TMP] = timer_match_p;
        ev[`MIC_SRC_TMA] = timer_match_a;
        ev[`MIC_SRC_EE] = eeprom_write_done;
        ev[`MIC_SRC_TBB] = timebase_b_tick;
        pending = st_reg.flag & st_reg.en;
        do_take = cpu_irq_window && st_reg.gie && !stack_full && pick_hit;
        sel = decode(paddr);
        bus_done = psel && penable && st_reg.pready;
        wr_a = bus_done && pwrite && (sel == MIC_SEL_A);
        wr_b = bus_done && pwrite && (sel == MIC_SEL_B);
    end

    always_comb begin
        st_next = st_reg;
        st_next.cmp_prev = cmp_out;
        st_next.deb_prev = debounce_out;
        st_next.prev_valid = 1'b1;
        // one wait state: pready rises in the second access cycle
        st_next.pready = psel && penable && !st_reg.pready;
        st_next.pslverr = psel && penable && !st_reg.pready && (sel == MIC_SEL_NONE);
        st_next.prdata = `MIC_RDATA_ZERO;
        if (psel && penable && !st_reg.pready && !pwrite) begin
            if (sel == MIC_SEL_A) begin
                st_next.prdata = {24'h00_0000, pack_a(st_reg)};
            end else if (sel == MIC_SEL_B) begin
                st_next.prdata = {24'h00_0000, pack_b(st_reg)};
            end
        end
        // software writes first, then service clears, then hardware events win
        if (wr_a) begin
            st_next.gie = pwdata[`MIC_A_GIE_BIT];
            st_next.en[`MIC_A_NSRC-1:0] = pwdata[`MIC_A_EN_LSB +: `MIC_A_NSRC];
            st_next.flag[`MIC_A_NSRC-1:0] = pwdata[`MIC_A_FLAG_LSB +: `MIC_A_NSRC];
        end
        if (wr_b) begin
            st_next.en[`MIC_NSRC-1:`MIC_A_NSRC] = pwdata[`MIC_B_EN_LSB +: `MIC_B_NSRC];
            st_next.flag[`MIC_NSRC-1:`MIC_A_NSRC] = pwdata[`MIC_B_FLAG_LSB +: `MIC_B_NSRC];
        end
        if (return_from_irq_instr_exec && !wr_a) begin
            st_next.gie = 1'b1;
        end
        st_next.pop = return_from_irq_instr_exec;
        st_next.take = do_take;
        if (do_take) begin
            st_next.flag[pick_idx] = 1'b0;
            st_next.gie = 1'b0;
            st_next.vector = VECTORS[pick_idx*`MIC_PC_W +: `MIC_PC_W];
            st_next.push_pc = cpu_next_pc;
        end
        // flags hold otherwise; an event beats any clear in the same cycle
        st_next.flag = st_next.flag | ev;
        st_next.wake = low_power_mode && ((st_next.flag & ~st_reg.flag) != '0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq_take = st_reg.take;
    assign irq_vector = st_reg.vector;
    assign stack_push_pc = st_reg.push_pc;
    assign stack_pop = st_reg.pop;
    assign wake_req = st_reg.wake;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_event_sets_flag;
        (ev != '0) |=> ((st_reg.flag & $past(ev)) == $past(ev));
    endproperty
    a_event_sets_flag: assert property (p_event_sets_flag)
        else $error("event did not set its flag");

    property p_take_needs_enable;
        st_reg.take |-> ($past(st_reg.flag & st_reg.en) != '0);
    endproperty
    a_take_needs_enable: assert property (p_take_needs_enable)
        else $error("vector taken without an enabled pending flag");

    property p_take_needs_gie;
        st_reg.take |-> $past(st_reg.gie);
    endproperty
    a_take_needs_gie: assert property (p_take_needs_gie)
        else $error("vector taken while global enable was low");

    property p_push_pc;
        st_reg.take |-> (st_reg.push_pc == $past(cpu_next_pc)) ##1 !st_reg.take;
    endproperty
    a_push_pc: assert property (p_push_pc)
        else $error("pushed pc wrong or take not single cycle");

    property p_return_from_irq_instr_pop_gie;
        (return_from_irq_instr_exec && !wr_a && !do_take) |=> (stack_pop && st_reg.gie);
    endproperty
    a_return_from_irq_instr_pop_gie: assert property (p_return_from_irq_instr_pop_gie)
        else $error("return did not pop or set global enable");

    property p_take_clears_gie;
        do_take |=> irq_take && !st_reg.gie ##1 (st_reg.gie || !irq_take);
    endproperty
    a_take_clears_gie: assert property (p_take_clears_gie)
        else $error("global enable not cleared on service");

    property p_stack_full_blocks;
        (stack_full && cpu_irq_window) |=> !irq_take;
    endproperty
    a_stack_full_blocks: assert property (p_stack_full_blocks)
        else $error("interrupt taken with full stack");

    property p_wake_on_rise;
        (low_power_mode && (ev & ~st_reg.flag) != '0) |=> wake_req;
    endproperty
    a_wake_on_rise: assert property (p_wake_on_rise)
        else $error("no wake-up on a rising flag");

    property p_wake_in_low_power;
        wake_req |-> $past(low_power_mode);
    endproperty
    a_wake_in_low_power: assert property (p_wake_in_low_power)
        else $error("wake-up outside a low-power mode");

    // flags fall only through a software write or a take, never by themselves
    property p_flag_holds;
        (!wr_a && !wr_b && !do_take)
            |=> ((st_reg.flag & $past(st_reg.flag)) == $past(st_reg.flag));
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("flag dropped without write or service");

    property p_take_clears_flag;
        (do_take && !ev[pick_idx]) |=> !st_reg.flag[$past(pick_idx)];
    endproperty
    a_take_clears_flag: assert property (p_take_clears_flag)
        else $error("serviced flag not cleared");

    property p_cmp_change;
        ($changed(cmp_out) && st_reg.prev_valid) |=> st_reg.flag[`MIC_SRC_CMP];
    endproperty
    a_cmp_change: assert property (p_cmp_change)
        else $error("comparator change did not set its flag");

    property p_deb_change;
        ($changed(debounce_out) && st_reg.prev_valid) |=> st_reg.flag[`MIC_SRC_DEB];
    endproperty
    a_deb_change: assert property (p_deb_change)
        else $error("debounce change did not set its flag");

    property p_pop_from_return_from_irq_instr;
        stack_pop |-> $past(return_from_irq_instr_exec);
    endproperty
    a_pop_from_return_from_irq_instr: assert property (p_pop_from_return_from_irq_instr)
        else $error("stack pop without a return");

    property p_prio_top;
        (do_take && pending[PRIO[`MIC_IDX_W-1:0]]) |-> (pick_idx == PRIO[`MIC_IDX_W-1:0]);
    endproperty
    a_prio_top: assert property (p_prio_top)
        else $error("highest ranked pending source not picked");

    property p_apb_wait;
        $rose(psel && penable) |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("bus answer not one wait state or not one cycle");

    property p_apb_err;
        (psel && penable && !pready) |=> (pslverr == ($past(sel) == MIC_SEL_NONE));
    endproperty
    a_apb_err: assert property (p_apb_err)
        else $error("error response does not match the address");

    property p_read_a_bits;
        (pready && !$past(pwrite) && $past(sel) == MIC_SEL_A) |-> (prdata[`MIC_A_GIE_BIT]
            == $past(st_reg.gie)) && (prdata[`MIC_DATA_W-1:`MIC_A_FLAG_LSB+`MIC_A_NSRC] == '0);
    endproperty
    a_read_a_bits: assert property (p_read_a_bits)
        else $error("first register read wrong global enable or top bits");

    property p_write_a_en;
        wr_a |=> (st_reg.en[`MIC_A_NSRC-1:0] == $past(pwdata[`MIC_A_EN_LSB +: `MIC_A_NSRC]));
    endproperty
    a_write_a_en: assert property (p_write_a_en)
        else $error("first register enables not written");

    property p_write_b_en;
        wr_b |=> (st_reg.en[`MIC_NSRC-1:`MIC_A_NSRC]
            == $past(pwdata[`MIC_B_EN_LSB +: `MIC_B_NSRC]));
    endproperty
    a_write_b_en: assert property (p_write_b_en)
        else $error("second register enables not written");

    c_take: cover property (irq_take);
    c_wake: cover property (wake_req);
    c_return_from_irq_instr_after_take: cover property (irq_take ##[1:50] stack_pop);
    c_apb_error: cover property (pready && pslverr);
    c_take_after_full: cover property (stack_full ##1 !stack_full ##[1:4] irq_take);
endmodule

// *** design/mic_params.svh ***
/*
 * Constants of the interrupt controller: bus offsets, field positions, source
 * numbering, widths, reset values and the default vector and priority tables.
 * Assumes it is included by the package and the design files by bare name.
 */
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

`define MIC_NSRC 7
`define MIC_IDX_W 3
`define MIC_PC_W 12
`define MIC_ADDR_W 12
`define MIC_DATA_W 32

// apb byte addresses of the two control registers
`define MIC_ADDR_CTRL_A 12'h000
`define MIC_ADDR_CTRL_B 12'h004

// source numbering
`define MIC_SRC_CMP 0
`define MIC_SRC_DEB 1
`define MIC_SRC_TBA 2
`define MIC_SRC_TMP 3
`define MIC_SRC_TMA 4
`define MIC_SRC_EE 5
`define MIC_SRC_TBB 6

// field layout: sources 0..2 live in ctrl_a, sources 3..6 in ctrl_b
`define MIC_A_GIE_BIT 0
`define MIC_A_EN_LSB 1
`define MIC_A_FLAG_LSB 4
`define MIC_A_NSRC 3
`define MIC_B_EN_LSB 0
`define MIC_B_FLAG_LSB 4
`define MIC_B_NSRC 4

`define MIC_CTRL_RESET 8'h00
`define MIC_RDATA_ZERO 32'h0000_0000

// vectors, source 6 in the top slot; match p and match a share one vector
`define MIC_VECTORS_DEF {12'h01C, 12'h018, 12'h014, 12'h014, 12'h00C, 12'h008, 12'h004}
// priority, slot 0 (low bits) is the highest: cmp, deb, tba, tmp, tma, ee, tbb
`define MIC_PRIO_DEF {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}

`endif

// *** design/mic_pkg.sv ***
/*
 * Types shared by the interrupt controller files: source vectors, addresses,
 * register select and the packed state of the top module.
 * Assumes mic_params.svh is on the include path.
 */
`include "mic_params.svh"

package mic_pkg;
    typedef logic [`MIC_NSRC-1:0] mic_src_t;
    typedef logic [`MIC_PC_W-1:0] mic_pc_t;
    typedef logic [`MIC_IDX_W-1:0] mic_idx_t;
    typedef logic [`MIC_ADDR_W-1:0] mic_addr_t;
    typedef logic [`MIC_DATA_W-1:0] mic_data_t;

    typedef enum logic [1:0] {
        MIC_SEL_A,
        MIC_SEL_B,
        MIC_SEL_NONE
    } mic_sel_e;

    typedef struct packed {
        mic_src_t flag;
        mic_src_t en;
        logic gie;
        logic cmp_prev;
        logic deb_prev;
        logic prev_valid;
        logic pready;
        logic pslverr;
        mic_data_t prdata;
        logic take;
        mic_pc_t vector;
        mic_pc_t push_pc;
        logic pop;
        logic wake;
    } mic_state_s;
endpackage

// *** design/mic_prio_pick.sv ***
/*
 * Fixed-priority picker: returns the highest ranked pending source.
 * Assumes the order table lists every source index once, slot 0 highest.
 */
`include "mic_params.svh"

module mic_prio_pick #(
    parameter logic [`MIC_NSRC*`MIC_IDX_W-1:0] ORDER = `MIC_PRIO_DEF
) (
    // request side
    input wire mic_pkg::mic_src_t pending,
    // result
    output logic hit,
    output mic_pkg::mic_idx_t idx
);
    import mic_pkg::*;

    always_comb begin
        mic_idx_t s;
        s = '0;
        hit = 1'b0;
        idx = '0;
        // walk from lowest rank up so the highest pending one is kept last
        for (int i = `MIC_NSRC - 1; i >= 0; i--) begin
            s = ORDER[i*`MIC_IDX_W +: `MIC_IDX_W];
            if (pending[s]) begin
                hit = 1'b1;
                idx = s;
            end
        end
    end
endmodule

// *** verif/mic_cpu_model.sv ***
/*
 * Behavioural cpu core and program stack that face the interrupt controller.
 * Assumes the controller pushes on irq_take and pops on stack_pop, and that
 * the bench commands each return-from-interrupt through return_from_irq_instr_req.
 */
module mic_cpu_model #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controller side
    input wire logic irq_take,
    input wire mic_pkg::mic_pc_t stack_push_pc,
    input wire logic stack_pop,
    output logic cpu_irq_window,
    output mic_pkg::mic_pc_t cpu_next_pc,
    output logic stack_full,
    output logic return_from_irq_instr_exec,
    // bench side
    input wire logic return_from_irq_instr_req,
    output mic_pkg::mic_pc_t top_pc
);
    timeunit 1ns;
    timeprecision 1ns;
    import mic_pkg::*;
    mic_pc_t stk [DEPTH];
    int sp;
    // always at a boundary: the quickest core the controller can meet
    assign cpu_irq_window = 1'b1;
    // next pc follows the depth so that every push is predictable
    assign cpu_next_pc = 12'h100 + 12'(sp);
    assign stack_full = (sp == DEPTH);
    assign return_from_irq_instr_exec = return_from_irq_instr_req;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= 0;
            top_pc <= '0;
        end else if (irq_take && sp < DEPTH) begin
            stk[sp] <= stack_push_pc;
            sp <= sp + 1;
        end else if (stack_pop && sp > 0) begin
            top_pc <= stk[sp - 1];
            sp <= sp - 1;
        end
    end
endmodule

// *** verif/tb_top.sv ***
/*
 * Self-checking bench of the interrupt controller: apb tasks, event pulses
 * and a cpu model with a two-deep stack.
 * Assumes the design answers apb with one wait state and takes in one cycle.
 */
`include "mic_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mic_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic cmp_out = 1'b0, debounce_out = 1'b0, low_power_mode = 1'b0, return_from_irq_instr_req = 1'b0;
    logic [6:2] ev = '0;
    mic_addr_t paddr = '0;
    mic_data_t pwdata = '0, prdata, q;
    logic pready, pslverr, cpu_irq_window, stack_full, return_from_irq_instr_exec, irq_take, stack_pop;
    logic wake_req, e;
    mic_pc_t cpu_next_pc, irq_vector, stack_push_pc, top_pc, vec, push;
    int takes = 0, wakes = 0, pops = 0, mismatches = 0, tests_run = 0;

    mic_irq_ctrl mic_irq_ctrl_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .cmp_out, .debounce_out, .timebase_a_tick(ev[2]),
        .timebase_b_tick(ev[6]), .eeprom_write_done(ev[5]), .timer_match_p(ev[3]),
        .timer_match_a(ev[4]), .cpu_irq_window, .cpu_next_pc, .stack_full, .return_from_irq_instr_exec,
        .low_power_mode, .irq_take, .irq_vector, .stack_push_pc, .stack_pop, .wake_req);
    mic_cpu_model mic_cpu_model_i (.pclk, .presetn, .irq_take, .stack_push_pc, .stack_pop,
        .cpu_irq_window, .cpu_next_pc, .stack_full, .return_from_irq_instr_exec, .return_from_irq_instr_req, .top_pc);

    always #20 pclk = ~pclk;

    always @(posedge pclk) begin
        if (irq_take === 1'b1) begin
            takes++;
            vec = irq_vector;
            push = stack_push_pc;
        end
        if (wake_req === 1'b1)
            wakes++;
        if (stack_pop === 1'b1)
            pops++;
    end

    task summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, g, x);
        end
    endtask

    // waits a few cycles after each transfer so events and takes settle
    task apb(input logic w, input mic_addr_t a, input mic_data_t d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken at the rising edge that sees pready high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            mismatches++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task rd(input mic_addr_t a, input mic_data_t x);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, x);
    endtask

    task wr(input mic_addr_t a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task pulse(input int s);
        @(posedge pclk);
        if (s == 0)
            cmp_out <= ~cmp_out;
        else if (s == 1)
            debounce_out <= ~debounce_out;
        else
            ev[s] <= 1'b1;
        @(posedge pclk);
        ev <= '0;
        repeat (2) @(posedge pclk);
    endtask

    task return_from_irq_instr;
        @(posedge pclk);
        return_from_irq_instr_req <= 1'b1;
        @(posedge pclk);
        return_from_irq_instr_req <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wr(12'h008, 8'hFF);
        chk(e, 1'b1);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_0000);
        chk(e, 1'b0);
        rd(`MIC_ADDR_CTRL_B, 32'h0000_0000);
        chk(e, 1'b0);
        rd(12'h008, 32'h0000_0000);
        chk(e, 1'b1);
        wr(`MIC_ADDR_CTRL_A, 8'hFE);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_007E);
        wr(`MIC_ADDR_CTRL_B, 8'hFF);
        rd(`MIC_ADDR_CTRL_B, 32'h0000_00FF);
        chk(takes, 0);
        wr(`MIC_ADDR_CTRL_B, 8'h00);
        wr(`MIC_ADDR_CTRL_A, 8'h01);
        $display("register test done");
        pulse(2);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_0041);
        chk(takes, 0);
        wr(`MIC_ADDR_CTRL_A, 8'h49);
        chk(takes, 1);
        chk(vec, 12'h00C);
        chk(push, 12'h100);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_0008);
        pulse(2);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_0048);
        return_from_irq_instr;
        chk(pops, 1);
        chk(top_pc, 12'h100);
        chk(takes, 2);
        $display("take and return test done");
        wr(`MIC_ADDR_CTRL_B, 8'h0F);
        wr(`MIC_ADDR_CTRL_A, 8'h0E);
        for (int s = 0; s < 7; s++)
            pulse(s);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_007E);
        rd(`MIC_ADDR_CTRL_B, 32'h0000_00FF);
        wr(`MIC_ADDR_CTRL_A, 8'h7F);
        chk(vec, 12'h004);
        chk(push, 12'h101);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_006E);
        wr(`MIC_ADDR_CTRL_A, 8'h6F);
        chk(takes, 3);
        return_from_irq_instr;
        chk(top_pc, 12'h101);
        chk(takes, 4);
        chk(vec, 12'h008);
        rd(`MIC_ADDR_CTRL_A, 32'h0000_004E);
        $display("priority and stack test done");
        wr(`MIC_ADDR_CTRL_A, 8'h00);
        wr(`MIC_ADDR_CTRL_B, 8'h00);
        @(posedge pclk);
        low_power_mode <= 1'b1;
        pulse(5);
        chk(wakes, 1);
        pulse(5);
        chk(wakes, 1);
        low_power_mode <= 1'b0;
        rd(`MIC_ADDR_CTRL_B, 32'h0000_0040);
        $display("wake test done");
        summarize();
    end

    // the tests need about 240 cycles; the 5000-cycle limit is about twenty times that
    initial begin
        #200us;
        mismatches++;
        summarize();
    end
endmodule
